// ---- src/lbdsp_local_bus_port.sv ----
`timescale 1ns/1ps
// Operation
// - wait for owner to release bus before driving
// - zero-wait acknowledge completes master transfer
// - narrow port DMA: never assert low acknowledge
// - address lines ignored during DMA transfers
// - dual-address DMA never retries or errors
// - unaligned burst start has at least one wait state
// - slave wait states by cycle kind
// - register access: two retries, 3/6 clock minimum
// - image choice selects slave image 0 or 1
module lbdsp_local_bus_port (
   input wire logic mclk,
   input wire logic reset_n,
   // master side
   input wire logic masterRequest,
   input wire logic masterWrite,
   input wire logic busOwned_n,
   input wire logic grantAcknowledge_n,
   input wire logic slaveTransferAck_n,
   output logic busOwnedDrive_n,
   output logic masterStart_n,
   output logic masterDone,
   // slave side
   input wire logic transferStart_n,
   input wire logic readNotWrite,
   input wire logic burst,
   input wire logic [31:0] address,
   input wire logic bridgeWindowSelect_n,
   input wire logic registerWindowSelect_n,
   input wire logic imageChoice,
   input wire logic writePosted,
   input wire logic delayedReady,
   // dma side
   input wire logic transferGrant_n,
   input wire logic dmaPending,
   input wire logic narrowPortSetting,
   output logic transferRequest_n,
   // termination
   output logic transferAck_n,
   output logic transferError_n,
   output logic transferRetry_n,
   output logic sizeAckLow_n,
   output logic sizeAckHigh_n,
   output logic imageSelected,
   output logic dualAddressCycle
);
   import lbdsp_pkg::*;

   typedef enum logic [1:0] {MIDLE, MWAIT_FREE, MRUN} lbdsp_mstate_type;
   typedef enum logic [1:0] {SIDLE, SWAIT, SACK} lbdsp_sstate_type;

   lbdsp_mstate_type mState_reg, mState_next;
   logic busOwnedDrive_next;
   logic masterStart_next;
   logic masterDone_next;

   lbdsp_sstate_type sState_reg, sState_next;
   logic ackPulse_next;
   logic retryPulse_next;
   logic lowAck_next;
   logic highAck_next;
   logic image_reg, image_next;
   logic dual_reg, dual_next;
   logic isRetry_reg, isRetry_next;
   logic isDma_reg, isDma_next;
   logic [1:0] regRetries_reg, regRetries_next;
   logic transfer_request_n_next;
   logic waitLoad;
   logic [2:0] waitValue;
   logic waitDone;

   lbdsp_wait_counter waitCounter (
      .mclk(mclk),
      .reset_n(reset_n),
      .load(waitLoad),
      .loadValue(waitValue),
      .done(waitDone)
   );

   // master: arbitration and termination
   always_comb begin
      mState_next = mState_reg;
      busOwnedDrive_next = !busOwnedDrive_n;
      masterStart_next = 1'b0;
      masterDone_next = 1'b0;
      case (mState_reg)
         MIDLE: begin
            if (masterRequest) begin
               mState_next = MWAIT_FREE;
            end
         end
         MWAIT_FREE: begin
            if (busOwned_n && grantAcknowledge_n) begin
               mState_next = MRUN;
               busOwnedDrive_next = 1'b1;
               masterStart_next = 1'b1;
            end
         end
         MRUN: begin
            if (!slaveTransferAck_n) begin
               mState_next = MIDLE;
               busOwnedDrive_next = 1'b0;
               masterDone_next = 1'b1;
            end
         end
         default: begin
            mState_next = MIDLE;
         end
      endcase
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         mState_reg <= MIDLE;
         busOwnedDrive_n <= 1'b1;
         masterStart_n <= 1'b1;
         masterDone <= 1'b0;
      end else begin
         mState_reg <= mState_next;
         busOwnedDrive_n <= !busOwnedDrive_next;
         masterStart_n <= !masterStart_next;
         masterDone <= masterDone_next;
      end
   end

   // slave: wait-state choice and termination
   always_comb begin
      sState_next = sState_reg;
      ackPulse_next = 1'b0;
      retryPulse_next = 1'b0;
      lowAck_next = 1'b0;
      highAck_next = 1'b0;
      image_next = image_reg;
      dual_next = dual_reg;
      isRetry_next = isRetry_reg;
      isDma_next = isDma_reg;
      regRetries_next = regRetries_reg;
      transfer_request_n_next = dmaPending;
      waitLoad = 1'b0;
      waitValue = WAIT_ZERO;
      case (sState_reg)
         SIDLE: begin
            if (!transferStart_n && !transferGrant_n) begin
               isDma_next = 1'b1;
               isRetry_next = 1'b0;
               dual_next = !bridgeWindowSelect_n;
               waitLoad = 1'b1;
               waitValue = WAIT_ZERO;
               sState_next = SWAIT;
            end else if (!transferStart_n && !registerWindowSelect_n) begin
               isDma_next = 1'b0;
               isRetry_next = !delayedReady && regRetries_reg < REG_RETRY_MAX;
               regRetries_next = isRetry_next ? regRetries_reg + 2'h1 : 2'h0;
               waitLoad = 1'b1;
               if (isRetry_next) begin
                  waitValue = WAIT_RETRY - 3'h1;
               end else if (readNotWrite) begin
                  waitValue = REG_READ_CLOCKS - 3'h2;
               end else begin
                  waitValue = REG_WRITE_CLOCKS - 3'h2;
               end
               sState_next = SWAIT;
            end else if (!transferStart_n && !bridgeWindowSelect_n) begin
               image_next = imageChoice;
               isDma_next = 1'b0;
               dual_next = 1'b0;
               waitLoad = 1'b1;
               isRetry_next = 1'b0;
               if (readNotWrite && !delayedReady) begin
                  isRetry_next = 1'b1;
                  waitValue = WAIT_RETRY;
               end else if (readNotWrite) begin
                  waitValue = burst ? WAIT_DELAYED_BURST_READ : WAIT_DELAYED_SINGLE;
               end else if (burst) begin
                  waitValue = WAIT_BURST_WRITE;
               end else if (writePosted) begin
                  waitValue = WAIT_POSTED_WRITE;
               end else if (!delayedReady) begin
                  isRetry_next = 1'b1;
                  waitValue = WAIT_RETRY;
               end else begin
                  waitValue = WAIT_DELAYED_SINGLE;
               end
               if (burst && address[ALIGN_BITS-1:0] != '0 && waitValue < WAIT_UNALIGNED_MIN) begin
                  waitValue = WAIT_UNALIGNED_MIN;
               end
               // counter and ack flop add one clock: load waits minus one
               waitValue = waitValue - 3'h1;
               sState_next = SWAIT;
            end
         end
         SWAIT: begin
            if (waitDone) begin
               sState_next = SACK;
               if (isRetry_reg && !(isDma_reg && dual_reg)) begin
                  retryPulse_next = 1'b1;
               end else begin
                  ackPulse_next = 1'b1;
                  highAck_next = 1'b1;
                  lowAck_next = !(isDma_reg && narrowPortSetting);
               end
            end
         end
         SACK: begin
            sState_next = SIDLE;
         end
         default: begin
            sState_next = SIDLE;
         end
      endcase
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         sState_reg <= SIDLE;
         transferAck_n <= 1'b1;
         transferRetry_n <= 1'b1;
         sizeAckLow_n <= 1'b1;
         sizeAckHigh_n <= 1'b1;
         // no error source in this port, so the pin stays negated
         transferError_n <= 1'b1;
         image_reg <= 1'b0;
         dual_reg <= 1'b0;
         isRetry_reg <= 1'b0;
         isDma_reg <= 1'b0;
         regRetries_reg <= 2'h0;
         transferRequest_n <= 1'b1;
      end else begin
         sState_reg <= sState_next;
         transferAck_n <= !ackPulse_next;
         transferRetry_n <= !retryPulse_next;
         sizeAckLow_n <= !lowAck_next;
         sizeAckHigh_n <= !highAck_next;
         transferError_n <= 1'b1;
         image_reg <= image_next;
         dual_reg <= dual_next;
         isRetry_reg <= isRetry_next;
         isDma_reg <= isDma_next;
         regRetries_reg <= regRetries_next;
         transferRequest_n <= !transfer_request_n_next;
      end
   end

   assign imageSelected = image_reg;
   assign dualAddressCycle = dual_reg;

   a_master_waits_owner: assert property (@(posedge mclk) disable iff (!reset_n)
      !masterStart_n |-> $past(busOwned_n) && $past(grantAcknowledge_n))
      else $error("master started while bus owned");
   a_master_zero_wait: assert property (@(posedge mclk) disable iff (!reset_n)
      (mState_reg == MRUN && !slaveTransferAck_n) |=> masterDone)
      else $error("master ignored zero-wait acknowledge");
   a_narrow_low_ack: assert property (@(posedge mclk) disable iff (!reset_n)
      (isDma_reg && narrowPortSetting && !sizeAckHigh_n) |-> sizeAckLow_n)
      else $error("low size acknowledge in narrow dma");
   a_dual_no_retry: assert property (@(posedge mclk) disable iff (!reset_n)
      (isDma_reg && dual_reg) |-> transferRetry_n && transferError_n)
      else $error("retry or error in dual-address dma");
   a_unaligned_burst_wait: assert property (@(posedge mclk) disable iff (!reset_n)
      (sState_reg == SIDLE && !transferStart_n && !bridgeWindowSelect_n
       && registerWindowSelect_n && transferGrant_n && burst
       && address[3:0] != 4'h0) |=> transferAck_n)
      else $error("unaligned burst acknowledged without wait");
   a_delayed_single_wait: assert property (@(posedge mclk) disable iff (!reset_n)
      (sState_reg == SIDLE && !transferStart_n && !bridgeWindowSelect_n
       && registerWindowSelect_n && transferGrant_n && readNotWrite && !burst
       && delayedReady) |=> transferAck_n [*2] ##1 !transferAck_n)
      else $error("delayed single read wait count wrong");
   a_reg_read_clocks: assert property (@(posedge mclk) disable iff (!reset_n)
      (sState_reg == SIDLE && !transferStart_n && !registerWindowSelect_n
       && transferGrant_n && readNotWrite && delayedReady)
       |=> transferAck_n [*2] ##1 !transferAck_n)
      else $error("register read acknowledge early");
   a_image_choice: assert property (@(posedge mclk) disable iff (!reset_n)
      (sState_reg == SIDLE && !transferStart_n && !bridgeWindowSelect_n
       && registerWindowSelect_n && transferGrant_n) |=> imageSelected == $past(imageChoice))
      else $error("wrong slave image");
endmodule // lbdsp_local_bus_port

// ---- src/lbdsp_pkg.sv ----
package lbdsp_pkg;
   // wait states as slave, counted in clocks between start and acknowledge
   localparam logic [2:0] WAIT_RETRY = 3'h1;
   localparam logic [2:0] WAIT_BURST_WRITE = 3'h1;
   localparam logic [2:0] WAIT_POSTED_WRITE = 3'h1;
   localparam logic [2:0] WAIT_DELAYED_SINGLE = 3'h2;
   localparam logic [2:0] WAIT_DELAYED_BURST_READ = 3'h1;
   localparam logic [2:0] WAIT_UNALIGNED_MIN = 3'h1;
   // register access: clocks from start to acknowledge (ack in that cycle)
   localparam logic [2:0] REG_READ_CLOCKS = 3'h3;
   localparam logic [2:0] REG_WRITE_CLOCKS = 3'h6;
   localparam logic [1:0] REG_RETRY_MAX = 2'h2;
   localparam int ALIGN_BITS = 4;
   localparam logic [2:0] WAIT_ZERO = 3'h0;

   typedef enum logic [1:0] {
      LBDSP_KIND_POSTED,
      LBDSP_KIND_DELAYED_DONE,
      LBDSP_KIND_RETRY
   } lbdsp_kind_type;
endpackage

// ---- src/lbdsp_wait_counter.sv ----
`timescale 1ns/1ps
module lbdsp_wait_counter (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic load,
   input wire logic [2:0] loadValue,
   output logic done
);
   logic [2:0] count_reg;
   logic [2:0] count_next;
   logic busy_reg;
   logic busy_next;

   always_comb begin
      count_next = count_reg;
      busy_next = busy_reg;
      if (load) begin
         count_next = loadValue;
         busy_next = 1'b1;
      end else if (busy_reg && count_reg != 3'h0) begin
         count_next = count_reg - 3'h1;
      end else begin
         busy_next = 1'b0;
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         count_reg <= 3'h0;
         busy_reg <= 1'b0;
      end else begin
         count_reg <= count_next;
         busy_reg <= busy_next;
      end
   end

   assign done = busy_reg && (count_reg == 3'h0);
endmodule // lbdsp_wait_counter

// ---- sim/lbdsp_bus_partner.sv ----
`timescale 1ns/1ps
module lbdsp_bus_partner (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic grab,
   input wire logic [3:0] holdCycles,
   input wire logic [3:0] ackDelay,
   input wire logic masterStart_n,
   output logic busOwned_n,
   output logic grantAcknowledge_n,
   output logic slaveTransferAck_n
);
   logic [3:0] holdCnt_reg;
   logic [3:0] ackCnt_reg;
   logic ackArm_reg;
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         holdCnt_reg <= 4'h0;
         ackCnt_reg <= 4'h0;
         ackArm_reg <= 1'b0;
         slaveTransferAck_n <= 1'b1;
      end else begin
         if (grab)
            holdCnt_reg <= holdCycles;
         else if (holdCnt_reg != 4'h0)
            holdCnt_reg <= holdCnt_reg - 4'h1;
         slaveTransferAck_n <= 1'b1;
         if (!masterStart_n && ackDelay == 4'h0) begin
            slaveTransferAck_n <= 1'b0;
         end else if (!masterStart_n) begin
            ackArm_reg <= 1'b1;
            ackCnt_reg <= ackDelay;
         end else if (ackArm_reg) begin
            ackCnt_reg <= ackCnt_reg - 4'h1;
            ackArm_reg <= ackCnt_reg != 4'h1;
            slaveTransferAck_n <= ackCnt_reg != 4'h1;
         end
      end
   end
   assign busOwned_n = holdCnt_reg < 4'h2;
   assign grantAcknowledge_n = holdCnt_reg == 4'h0;
endmodule // lbdsp_bus_partner

// ---- sim/lbdsp_local_bus_port_tb.sv ----
`timescale 1ns/1ps
module lbdsp_local_bus_port_tb;
   logic mclk = 1'b0, reset_n = 1'b0, live = 1'b0, grab = 1'b0;
   logic masterRequest = 1'b0, masterWrite = 1'b0, transferStart_n = 1'b1, readNotWrite = 1'b1;
   logic burst = 1'b0, bridgeWindowSelect_n = 1'b1, registerWindowSelect_n = 1'b1;
   logic imageChoice = 1'b0, writePosted = 1'b0, delayedReady = 1'b0, transferGrant_n = 1'b1;
   logic dmaPending = 1'b0, narrowPortSetting = 1'b0, pDma = 1'b0, pAck = 1'b1, pFree = 1'b1;
   logic [31:0] address = 32'h0;
   logic [3:0] holdCycles = 4'h0, ackDelay = 4'h0;
   logic busOwned_n, grantAcknowledge_n, slaveTransferAck_n, busOwnedDrive_n, masterStart_n;
   logic masterDone, transferRequest_n, transferAck_n, transferError_n, transferRetry_n;
   logic sizeAckLow_n, sizeAckHigh_n, imageSelected, dualAddressCycle;
   int errors = 0, n_tests = 0, regRetry = 0;
   // 10 MHz stays below the fast-termination limit
   always #50 mclk = ~mclk;
   lbdsp_bus_partner i_lbdsp_bus_partner (.mclk(mclk), .reset_n(reset_n), .grab(grab),
      .holdCycles(holdCycles), .ackDelay(ackDelay), .masterStart_n(masterStart_n),
      .busOwned_n(busOwned_n), .grantAcknowledge_n(grantAcknowledge_n),
      .slaveTransferAck_n(slaveTransferAck_n));
   lbdsp_local_bus_port i_lbdsp_local_bus_port (.mclk(mclk), .reset_n(reset_n),
      .masterRequest(masterRequest), .masterWrite(masterWrite), .busOwned_n(busOwned_n),
      .grantAcknowledge_n(grantAcknowledge_n), .slaveTransferAck_n(slaveTransferAck_n),
      .busOwnedDrive_n(busOwnedDrive_n), .masterStart_n(masterStart_n),
      .masterDone(masterDone), .transferStart_n(transferStart_n),
      .readNotWrite(readNotWrite), .burst(burst), .address(address),
      .bridgeWindowSelect_n(bridgeWindowSelect_n),
      .registerWindowSelect_n(registerWindowSelect_n), .imageChoice(imageChoice),
      .writePosted(writePosted), .delayedReady(delayedReady),
      .transferGrant_n(transferGrant_n), .dmaPending(dmaPending),
      .narrowPortSetting(narrowPortSetting), .transferRequest_n(transferRequest_n),
      .transferAck_n(transferAck_n), .transferError_n(transferError_n),
      .transferRetry_n(transferRetry_n), .sizeAckLow_n(sizeAckLow_n),
      .sizeAckHigh_n(sizeAckHigh_n), .imageSelected(imageSelected),
      .dualAddressCycle(dualAddressCycle));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         errors++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic stop_test;
      $display("errors %0d comparisons %0d", errors, n_tests);
      if (errors == 0 && n_tests > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   always @(posedge mclk) begin
      dmaPending <= 1'($urandom_range(0, 1));
      pDma <= dmaPending;
      pAck <= slaveTransferAck_n;
      pFree <= busOwned_n && grantAcknowledge_n;
   end
   always @(negedge mclk) begin
      if (live) begin
         check(transferRequest_n, !pDma);
         check(masterDone, !pAck);
         check(transferError_n, 1'b1);
         if (masterStart_n === 1'b0) begin
            check(pFree, 1'b1);
            check(busOwnedDrive_n, 1'b0);
         end
      end
   end
   task automatic master(input logic [3:0] h, input logic [3:0] d);
      int n;
      bit started;
      started = 0;
      @(posedge mclk);
      grab <= 1'b1;
      holdCycles <= h;
      ackDelay <= d;
      masterWrite <= 1'($urandom_range(0, 1));
      @(posedge mclk);
      grab <= 1'b0;
      masterRequest <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(posedge mclk);
         if (started)
            masterRequest <= 1'b0;
         #1;
         if (masterStart_n === 1'b0)
            started = 1;
         if (masterDone === 1'b1)
            break;
      end
      if (n == 40) begin
         errors++;
         stop_test();
      end
      check(busOwnedDrive_n, 1'b1);
   endtask
   task automatic slave(input bit gn, cb, cr, rnw, bu, input logic [31:0] a,
                        input bit post, rdy, img, nar);
      int w;
      int n;
      bit r;
      if (!gn) begin
         r = 0;
         // dma gets the one wait state of the counter
         w = 1;
      end else if (!cr) begin
         r = !rdy && regRetry < 2;
         w = r ? 1 : (rnw ? 2 : 5);
         regRetry = r ? regRetry + 1 : 0;
      end else begin
         r = !rdy && (rnw || (!bu && !post));
         w = (r || bu || (!rnw && post)) ? 1 : 2;
      end
      @(posedge mclk);
      transferStart_n <= 1'b0;
      transferGrant_n <= gn;
      bridgeWindowSelect_n <= cb;
      registerWindowSelect_n <= cr;
      readNotWrite <= rnw;
      burst <= bu;
      address <= a;
      writePosted <= post;
      delayedReady <= rdy;
      imageChoice <= img;
      narrowPortSetting <= nar;
      for (n = 1; n < 20; n++) begin
         @(posedge mclk);
         transferStart_n <= 1'b1;
         #1;
         if (transferAck_n === 1'b0 || transferRetry_n === 1'b0)
            break;
      end
      if (n == 20) begin
         errors++;
         stop_test();
      end
      check(n, w + 1);
      check(transferRetry_n, !r);
      check(sizeAckHigh_n, r);
      check(sizeAckLow_n, r || (!gn && nar));
      if (!gn)
         check(dualAddressCycle, !cb);
      else if (cr)
         check(imageSelected, img);
      @(posedge mclk);
      transferGrant_n <= 1'b1;
      registerWindowSelect_n <= 1'b1;
      bridgeWindowSelect_n <= 1'b1;
      address <= ~a;
      @(posedge mclk);
   endtask
   initial begin
      bit gn, cb, cr, rnw, bu, post, rdy;
      void'($urandom(32'h1777));
      repeat (4) @(posedge mclk);
      reset_n <= 1'b1;
      @(posedge mclk);
      live <= 1'b1;
      master(4'h5, 4'h0);
      master(4'h0, 4'h2);
      repeat (3) slave(1, 1, 0, 1, 0, 32'h40, 0, 0, 0, 0);
      slave(1, 1, 0, 0, 0, 32'h44, 0, 1, 0, 0);
      slave(1, 0, 1, 1, 1, 32'h1004, 0, 1, 1, 0);
      for (int i = 0; i < 60; i++) begin
         gn = $urandom_range(0, 3) != 0;
         cb = 1'($urandom_range(0, 1));
         // exactly one window per cycle; with both the register window wins, with none only dma answers
         cr = !cb;
         rnw = 1'($urandom_range(0, 1));
         bu = 1'($urandom_range(0, 1));
         post = 1'($urandom_range(0, 1));
         rdy = 1'($urandom_range(0, 1)) || !cr;
         // select marks the mode, address random
         slave(gn, cb, cr, rnw, bu, $urandom, post, rdy, 1'($urandom), 1'($urandom));
      end
      stop_test();
   end
endmodule // lbdsp_local_bus_port_tb
